/* File: logic/iicrc_map.svh */
// Register offsets, field positions, reset values and timing of the two-wire interface core
`ifndef IICRC_MAP_SVH
`define IICRC_MAP_SVH
// Byte offsets on the register bus
`define IICRC_OFS_CONTROL 4'h0
`define IICRC_OFS_STATUS 4'h4
`define IICRC_OFS_DATA 4'h8
`define IICRC_OFS_FORMAT 4'hc
// Control fields
`define IICRC_CTL_ENABLE 7
`define IICRC_CTL_IRQEN 6
`define IICRC_CTL_MASTER 5
`define IICRC_CTL_DIR 4
`define IICRC_CTL_SERIAL 3
// Format and own-address fields
`define IICRC_FMT_ORDER 7
`define IICRC_FMT_WAIT 6
`define IICRC_FMT_FIXED 8'h38
`define IICRC_ADR_FORMAT 0
// Status fields
`define IICRC_STS_BUSY 7
`define IICRC_STS_IRQ 6
`define IICRC_STS_ADDRESSED 5
`define IICRC_STS_ACKB 0
// Reset values
`define IICRC_RST_CONTROL 8'h00
`define IICRC_RST_FORMAT 8'h38
`define IICRC_RST_ADDRESS 8'h00
// Master clock half period
`define IICRC_CLK_NS 4
`define IICRC_SCL_HALF_NS 5000
`define IICRC_SCL_HALF_CYC ((`IICRC_SCL_HALF_NS + `IICRC_CLK_NS - 1) / `IICRC_CLK_NS)
`endif

/* File: logic/iicrc_pkg.sv */
// Types shared by the two-wire interface core
package iicrc_pkg;
    // Master line sequencer states
    typedef enum logic [2:0] {
        MS_IDLE     = 3'b000,
        MS_START    = 3'b001,
        MS_RUN      = 3'b010,
        MS_STOP_LOW = 3'b011,
        MS_STOP     = 3'b100
    } iicrc_mstate_t;
    // Register bus address type
    typedef logic [3:0] iicrc_addr_t;
endpackage

/* File: logic/iicrc_core.sv */
// Two-wire serial interface core with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "iicrc_map.svh"
module iicrc_core #(
    parameter int SCL_HALF = `IICRC_SCL_HALF_CYC
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 standby_i,
    // Wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire iicrc_pkg::iicrc_addr_t adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic [31:0]               dat_o,
    output logic                      ack_o,
    // Chip mode
    input  wire logic                 expanded_mode_i,
    // Two-wire pins
    input  wire logic                 scl_i,
    output logic                      scl_o,
    output logic                      scl_oe_o,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    // Interrupt to the CPU
    output logic                      irq_o
);
    import iicrc_pkg::*;

    // Number of data bits for a bit-count code
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        data_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
    endfunction

    logic            rst;              // Chip reset or hardware standby
    logic            scl_s1, scl_s2, scl_s3; // Clock pin synchroniser and history
    logic            sda_s1, sda_s2, sda_s3; // Data pin synchroniser and history
    logic            scl_rise, scl_fall, start_det, stop_det;
    logic [7:0]      ctl_reg;          // interface_control
    logic [7:0]      fmt_reg;          // transfer_format
    logic [7:0]      sar_reg;          // own_slave_address
    logic [7:0]      shift_reg;        // shift_data
    logic            irq_reg, irq_seen_reg, ackb_reg, busy_reg;
    logic            go_reg;           // Frame launched
    logic [3:0]      bit_cnt_reg;      // Bits done in current frame
    logic            wait_reg;         // Waiting before acknowledge
    logic            addr_phase_reg;   // Frame is the address byte
    logic            addressed_reg;    // Selected as slave
    logic            ignore_reg;       // Not selected, idle until next start
    logic            sda_pull_reg, msda_reg, hold_reg, scl_gen_reg;
    iicrc_mstate_t   mstate_reg;
    logic [15:0]     timer_reg;
    logic            enable, master, dir, serial, active, tmo;
    logic [3:0]      dbits, flen;
    logic            wb_req, wb_wr, wb_rd, wr_data, rd_data, wr_sts;
    logic            out_bit, in_last, hold_want;
    logic [7:0]      shift_in;
    logic            irq_set, irq_clr, addr_match;

    assign rst     = rst_i | standby_i;
    assign enable  = ctl_reg[`IICRC_CTL_ENABLE];
    assign master  = ctl_reg[`IICRC_CTL_MASTER];
    assign dir     = ctl_reg[`IICRC_CTL_DIR];
    assign serial  = ctl_reg[`IICRC_CTL_SERIAL];
    assign dbits   = data_bits(fmt_reg[2:0]);
    assign flen    = serial ? dbits : dbits + 4'h1;
    assign active  = enable & go_reg & ~ignore_reg;
    assign tmo     = (timer_reg == 16'h0);

    // Bus strobes, one per transaction
    assign wb_req  = cyc_i & stb_i & ~ack_o;
    assign wb_wr   = wb_req & we_i & sel_i[0];
    assign wb_rd   = wb_req & ~we_i;
    assign wr_data = wb_wr & (adr_i == `IICRC_OFS_DATA);
    assign rd_data = wb_rd & (adr_i == `IICRC_OFS_DATA);
    assign wr_sts  = wb_wr & (adr_i == `IICRC_OFS_STATUS);

    // Line events from synchronised pins
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // Outgoing bit and incoming shift, by order
    assign out_bit  = fmt_reg[`IICRC_FMT_ORDER] ? shift_reg[0] : shift_reg[7];
    assign shift_in = fmt_reg[`IICRC_FMT_ORDER] ? {sda_s2, shift_reg[7:1]} : {shift_reg[6:0], sda_s2};
    assign in_last  = active & scl_rise & (bit_cnt_reg == dbits - 4'h1);
    assign addr_match = (shift_in[7:1] == sar_reg[7:1]);
    assign hold_want  = wait_reg | (~master & addressed_reg & ~go_reg);

    // Flag events
    assign irq_set = (in_last & ~serial & fmt_reg[`IICRC_FMT_WAIT])
                   | (active & scl_rise & (bit_cnt_reg + 4'h1 == flen))
                   | (in_last & addr_phase_reg & addr_match);
    assign irq_clr = wr_sts & ~dat_i[`IICRC_STS_IRQ] & irq_seen_reg;

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // Wishbone acknowledge and read data
    always_ff @(posedge clk_i) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= wb_req;
            dat_o <= 32'h0;
            if (wb_rd) begin
                if (adr_i == `IICRC_OFS_CONTROL) begin
                    dat_o[7:0] <= ctl_reg;
                end else if (adr_i == `IICRC_OFS_STATUS) begin
                    dat_o[7:0] <= {busy_reg, irq_reg, addressed_reg, 4'h0, ackb_reg};
                end else if (adr_i == `IICRC_OFS_DATA) begin
                    dat_o[7:0] <= shift_reg;
                end else if (adr_i == `IICRC_OFS_FORMAT) begin
                    // Shared offset, enable picks the register
                    dat_o[7:0] <= enable ? (fmt_reg | `IICRC_FMT_FIXED) : sar_reg;
                end
            end
        end
    end

    // Control register, direction bit also updated by address match
    always_ff @(posedge clk_i) begin
        if (rst) begin
            ctl_reg <= `IICRC_RST_CONTROL;
        end else if (wb_wr & (adr_i == `IICRC_OFS_CONTROL)) begin
            ctl_reg <= dat_i[7:0];
        end else if (in_last & addr_phase_reg & addr_match) begin
            ctl_reg[`IICRC_CTL_DIR] <= shift_in[0];   // Read request makes slave transmit
        end
    end

    // Format and own-address registers on a shared offset
    always_ff @(posedge clk_i) begin
        if (rst) begin
            fmt_reg <= `IICRC_RST_FORMAT;
            sar_reg <= `IICRC_RST_ADDRESS;
        end else if (wb_wr & (adr_i == `IICRC_OFS_FORMAT)) begin
            if (enable) begin
                fmt_reg <= (dat_i[7:0] & 8'hc7) | `IICRC_FMT_FIXED;
            end else begin
                sar_reg <= dat_i[7:0];
            end
        end
    end

    // Interrupt flag: read as one arms, write zero clears, set wins
    always_ff @(posedge clk_i) begin
        if (rst) begin
            irq_reg      <= 1'b0;
            irq_seen_reg <= 1'b0;
        end else begin
            if (irq_set) begin
                irq_reg <= 1'b1;
            end else if (irq_clr) begin
                irq_reg <= 1'b0;
            end
            if (irq_set | irq_clr) begin
                irq_seen_reg <= 1'b0;
            end else if (wb_rd & (adr_i == `IICRC_OFS_STATUS) & irq_reg) begin
                irq_seen_reg <= 1'b1;
            end
        end
    end

    // Acknowledge level and bus busy
    always_ff @(posedge clk_i) begin
        if (rst) begin
            ackb_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            if (active & scl_rise & ~serial & (bit_cnt_reg == dbits) & dir & ~addr_phase_reg) begin
                ackb_reg <= sda_s2;              // Acknowledge seen from receiver
            end else if (wr_sts) begin
                ackb_reg <= dat_i[`IICRC_STS_ACKB];
            end
            if (start_det) begin
                busy_reg <= 1'b1;
            end else if (stop_det) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Shift data register, left unset by reset
    always_ff @(posedge clk_i) begin
        if (wr_data) begin
            shift_reg <= dat_i[7:0];
        end else if (active & scl_rise & (bit_cnt_reg < dbits)) begin
            shift_reg <= shift_in;
        end
    end

    // Frame launch, bit counting and slave selection
    always_ff @(posedge clk_i) begin
        if (rst) begin
            go_reg         <= 1'b0;
            bit_cnt_reg    <= 4'h0;
            wait_reg       <= 1'b0;
            addr_phase_reg <= 1'b0;
            addressed_reg  <= 1'b0;
            ignore_reg     <= 1'b0;
        end else if (~enable | stop_det) begin
            go_reg         <= 1'b0;
            bit_cnt_reg    <= 4'h0;
            wait_reg       <= 1'b0;
            addr_phase_reg <= 1'b0;
            addressed_reg  <= 1'b0;
            ignore_reg     <= 1'b0;
        end else if (start_det) begin
            bit_cnt_reg <= 4'h0;
            wait_reg    <= 1'b0;
            ignore_reg  <= 1'b0;
            if (~master & ~sar_reg[`IICRC_ADR_FORMAT]) begin
                go_reg         <= 1'b1;  // Address byte received automatically
                addr_phase_reg <= 1'b1;
                addressed_reg  <= 1'b0;
            end else begin
                go_reg         <= 1'b0;
                addr_phase_reg <= 1'b0;
                addressed_reg  <= ~master;
            end
        end else begin
            if ((wr_data & dir) | (rd_data & ~dir)) begin
                go_reg <= 1'b1;
            end
            if (irq_clr) begin
                wait_reg <= 1'b0;
            end
            if (active & scl_rise) begin
                if (in_last & ~serial & fmt_reg[`IICRC_FMT_WAIT]) begin
                    wait_reg <= 1'b1;
                end
                if (in_last & addr_phase_reg) begin
                    if (addr_match) begin
                        addressed_reg <= 1'b1;
                    end else begin
                        ignore_reg     <= 1'b1;
                        go_reg         <= 1'b0;
                        addr_phase_reg <= 1'b0;
                    end
                end
                if (bit_cnt_reg + 4'h1 == flen) begin
                    bit_cnt_reg    <= 4'h0;
                    go_reg         <= 1'b0;
                    addr_phase_reg <= 1'b0;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end
        end
    end

    // Data line drive on each falling clock edge
    always_ff @(posedge clk_i) begin
        if (rst) begin
            sda_pull_reg <= 1'b0;
        end else if (~active) begin
            if (~enable | scl_fall) begin
                sda_pull_reg <= 1'b0;
            end
        end else if (scl_fall | (~scl_s2 & (bit_cnt_reg == 4'h0))) begin
            // First bit is placed while the clock is still low after launch
            if (bit_cnt_reg < dbits) begin
                sda_pull_reg <= dir & ~addr_phase_reg & ~out_bit;
            end else if (addr_phase_reg) begin
                sda_pull_reg <= 1'b1;                        // Acknowledge own address
            end else begin
                sda_pull_reg <= ~dir & ~ackb_reg;            // Receiver sends chosen level
            end
        end
    end

    // Clock hold for wait and for an addressed slave between frames
    always_ff @(posedge clk_i) begin
        if (rst) begin
            hold_reg <= 1'b0;
        end else if (~enable | ~hold_want) begin
            hold_reg <= 1'b0;
        end else if (scl_fall) begin
            hold_reg <= 1'b1;
        end
    end

    // Master start, clocking and stop sequencer
    always_ff @(posedge clk_i) begin
        if (rst) begin
            mstate_reg  <= MS_IDLE;
            timer_reg   <= 16'h0;
            scl_gen_reg <= 1'b0;
            msda_reg    <= 1'b0;
        end else if (~enable | ~master) begin
            mstate_reg  <= MS_IDLE;
            scl_gen_reg <= 1'b0;
            msda_reg    <= 1'b0;
        end else begin
            timer_reg <= tmo ? 16'h0 : timer_reg - 16'h1;
            case (mstate_reg)
                MS_IDLE: begin
                    if (wr_sts & dat_i[`IICRC_STS_BUSY] & ~busy_reg) begin
                        msda_reg   <= 1'b1;          // Data low while clock high
                        timer_reg  <= 16'(SCL_HALF - 1);
                        mstate_reg <= MS_START;
                    end
                end
                MS_START: begin
                    if (tmo) begin
                        scl_gen_reg <= 1'b1;
                        msda_reg    <= 1'b0;
                        timer_reg   <= 16'(SCL_HALF - 1);
                        mstate_reg  <= MS_RUN;
                    end
                end
                MS_RUN: begin
                    if (wr_sts & ~dat_i[`IICRC_STS_BUSY] & busy_reg) begin
                        mstate_reg <= MS_STOP_LOW;
                        timer_reg  <= 16'(SCL_HALF - 1);
                    end else if (tmo & ((go_reg & ~wait_reg) | ~scl_gen_reg)) begin
                        scl_gen_reg <= ~scl_gen_reg; // Ends each frame with clock low
                        timer_reg   <= 16'(SCL_HALF - 1);
                    end else if (scl_gen_reg & ~go_reg) begin
                        timer_reg <= 16'(SCL_HALF - 1); // Full low half after launch
                    end
                end
                MS_STOP_LOW: begin
                    scl_gen_reg <= 1'b1;
                    msda_reg    <= 1'b1;
                    if (tmo) begin
                        scl_gen_reg <= 1'b0;
                        timer_reg   <= 16'(SCL_HALF - 1);
                        mstate_reg  <= MS_STOP;
                    end
                end
                MS_STOP: begin
                    if (tmo) begin
                        msda_reg   <= 1'b0;          // Data rises while clock high
                        mstate_reg <= MS_IDLE;
                    end
                end
                default: begin
                    mstate_reg <= MS_IDLE;
                end
            endcase
        end
    end

    // Registered pin drives and interrupt
    always_ff @(posedge clk_i) begin
        if (rst) begin
            scl_o    <= 1'b0;
            sda_o    <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            scl_o    <= 1'b0;
            sda_o    <= 1'b0;
            scl_oe_o <= enable & (scl_gen_reg | hold_reg);
            sda_oe_o <= enable & ~expanded_mode_i & (sda_pull_reg | msda_reg);
            irq_o    <= irq_reg & ctl_reg[`IICRC_CTL_IRQEN];
        end
    end
endmodule
`default_nettype wire

/* File: sim/iicrc_core_monitor.sv */
// Concurrent checks on the ports of the two-wire interface core
`timescale 1ns/10ps
`default_nettype none
`include "iicrc_map.svh"
module iicrc_core_monitor (
    // Clock and resets
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   standby_i,
    // Register bus
    input wire logic                   cyc_i,
    input wire logic                   stb_i,
    input wire logic                   we_i,
    input wire iicrc_pkg::iicrc_addr_t adr_i,
    input wire logic [3:0]             sel_i,
    input wire logic [31:0]            dat_i,
    input wire logic [31:0]            dat_o,
    input wire logic                   ack_o,
    // Pins and interrupt
    input wire logic                   expanded_mode_i,
    input wire logic                   scl_oe_o,
    input wire logic                   sda_oe_o,
    input wire logic                   irq_o
);
    import iicrc_pkg::*;
    logic en_q;    // Shadow of the module enable
    logic ien_q;   // Shadow of the interrupt enable
    logic take;    // Request taken at this edge
    logic wr_ctl;  // Control write taken
    logic clr_sts; // Status write with flag bit zero
    assign take    = cyc_i && stb_i && !ack_o;
    assign wr_ctl  = take && we_i && sel_i[0] && adr_i == `IICRC_OFS_CONTROL;
    assign clr_sts = take && we_i && sel_i[0] && adr_i == `IICRC_OFS_STATUS && !dat_i[6];
    // Follow the control bits as the host writes them
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            en_q  <= 1'b0;
            ien_q <= 1'b0;
        end else if (wr_ctl) begin
            en_q  <= dat_i[7];
            ien_q <= dat_i[6];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || standby_i);
    // Read of the format register while enabled
    sequence fmt_read_s;
        take && !we_i && adr_i == `IICRC_OFS_FORMAT && en_q ##1 ack_o;
    endsequence
    // Interrupt line dropping
    sequence irq_drop_s;
        irq_o ##1 !irq_o;
    endsequence
    bus_answer_a: assert property (take |=> ack_o) else $error("no answer to a request");
    ack_single_a: assert property (ack_o |=> !ack_o) else $error("answer longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("answer without request");
    read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
    reserved_ones_a: assert property (fmt_read_s |-> dat_o[5:3] == 3'b111)
        else $error("reserved format bits not one");
    pins_float_a: assert property (!en_q && !$past(en_q) |-> !scl_oe_o && !sda_oe_o)
        else $error("pin driven while disabled");
    wait_pin_a: assert property (expanded_mode_i && $past(expanded_mode_i) |-> !sda_oe_o)
        else $error("data pin driven in expanded mode");
    irq_gate_a: assert property (irq_o |-> ien_q || $past(ien_q))
        else $error("interrupt while masked");
    flag_clear_a: assert property (irq_drop_s |-> $past(clr_sts, 1) || $past(clr_sts, 2) ||
        $past(wr_ctl, 1) || $past(wr_ctl, 2)) else $error("interrupt dropped without clear");
endmodule
bind iicrc_core iicrc_core_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .expanded_mode_i(expanded_mode_i), .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/iicrc_bus_model.sv */
// Slave device on the two-wire line that captures one byte and acknowledges it
`timescale 1ns/10ps
`default_nettype none
module iicrc_bus_model (
    // Resolved line levels
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    // Line drive and observations
    output logic            sda_oe_o,
    output logic [7:0]      rx_o,
    output logic [3:0]      nbits_o,
    output logic            busy_o
);
    initial begin
        sda_oe_o = 1'b0;
        rx_o     = 8'h00;
        nbits_o  = 4'h0;
        busy_o   = 1'b0;
    end
    // Start restarts the count, stop ends the frame
    always @(negedge sda_i) if (scl_i === 1'b1) begin
        nbits_o = 4'h0;
        busy_o  = 1'b1;
    end
    always @(posedge sda_i) if (scl_i === 1'b1) busy_o = 1'b0;
    // Count every clock rise and keep the first eight bits, first bit highest
    always @(posedge scl_i) if (busy_o) begin
        nbits_o = nbits_o + 4'h1;
        if (nbits_o <= 4'h8) rx_o = {rx_o[6:0], sda_i};
    end
    // Pull data low through the acknowledge bit only, released line goes high
    always @(negedge scl_i) sda_oe_o = busy_o && nbits_o == 4'h8;
endmodule
`default_nettype wire

/* File: sim/iicrc_core_tb.sv */
// Self-checking bench of the two-wire interface core
`timescale 1ns/10ps
`default_nettype none
`include "iicrc_map.svh"
module iicrc_core_tb;
    import iicrc_pkg::*;
    localparam int HALF = 8;  // Short line half period, 64 ns line clock
    logic        clk_i, rst_i, standby_i, cyc_i, stb_i, we_i, ack_o, expanded_mode_i;
    logic [3:0]  sel_i;
    iicrc_addr_t adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic        scl_oe_o, sda_oe_o, irq_o, p_sda_oe, p_busy, scl_w, sda_w;
    logic [7:0]  p_rx;
    logic [3:0]  p_bits;
    int          n_fail, checks, n;
    assign scl_w = !scl_oe_o;               // Pull-up, nobody stretches the clock
    assign sda_w = !(sda_oe_o || p_sda_oe); // Pull-up on data
    iicrc_core #(.SCL_HALF(HALF)) uut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .expanded_mode_i(expanded_mode_i), .scl_i(scl_w), .scl_o(),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
    iicrc_bus_model u_dev (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(p_sda_oe), .rx_o(p_rx),
        .nbits_o(p_bits), .busy_o(p_busy));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task wb(input logic w, input iicrc_addr_t a, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(0, 1, "bus timeout");
        r = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask
    task wr(input iicrc_addr_t a, input logic [7:0] d);
        wb(1'b1, a, d, rd);
    endtask
    task rdc(input iicrc_addr_t a, input logic [31:0] e, input string m);
        wb(1'b0, a, 8'h00, rd);
        chk(rd, e, m);
    endtask
    task t_reset;
        rdc(`IICRC_OFS_CONTROL, 32'h00, "control reset");
        rdc(`IICRC_OFS_FORMAT, 32'h00, "address reset");
        wr(4'h2, 8'hff);
        rdc(4'h2, 32'h00, "unmapped read");
        wr(`IICRC_OFS_CONTROL, 8'h80);
        rdc(`IICRC_OFS_FORMAT, 32'h38, "format reset");
        $display("test reset values done");
    endtask
    task t_regs;
        wr(`IICRC_OFS_CONTROL, 8'h00);
        wr(`IICRC_OFS_FORMAT, 8'ha5);
        rdc(`IICRC_OFS_FORMAT, 32'ha5, "own address");
        wr(`IICRC_OFS_CONTROL, 8'h80);
        wr(`IICRC_OFS_FORMAT, 8'h00);
        rdc(`IICRC_OFS_FORMAT, 32'h38, "reserved ones");
        wr(`IICRC_OFS_FORMAT, 8'hc0);
        rdc(`IICRC_OFS_FORMAT, 32'hf8, "order and wait bits");
        expanded_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(sda_oe_o, 1'b0, "expanded mode drive");
        expanded_mode_i <= 1'b0;
        wr(`IICRC_OFS_CONTROL, 8'h00);
        rdc(`IICRC_OFS_FORMAT, 32'ha5, "shared offset");
        $display("test register access done");
    endtask
    task t_standby;
        @(posedge clk_i);
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        rdc(`IICRC_OFS_CONTROL, 32'h00, "control after standby");
        rdc(`IICRC_OFS_FORMAT, 32'h00, "address after standby");
        wr(`IICRC_OFS_CONTROL, 8'h80);
        rdc(`IICRC_OFS_FORMAT, 32'h38, "format after standby");
        $display("test standby done");
    endtask
    task t_master;
        wr(`IICRC_OFS_CONTROL, 8'hf0);
        wr(`IICRC_OFS_FORMAT, 8'h80);
        wr(`IICRC_OFS_STATUS, 8'h80);
        for (int i = 0; i < 200 && scl_w !== 1'b0; i++) @(posedge clk_i);
        chk(p_busy, 1'b1, "start on line");
        wr(`IICRC_OFS_DATA, 8'ha6);
        for (int i = 0; i < 2000 && irq_o !== 1'b1; i++) @(posedge clk_i);
        chk(irq_o, 1'b1, "end of frame interrupt");
        chk(p_bits, 4'h9, "bits in frame");
        chk(p_rx, 8'h65, "first bit lowest");
        wr(`IICRC_OFS_CONTROL, 8'hb0);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0, "interrupt masked");
        wr(`IICRC_OFS_CONTROL, 8'hf0);
        wr(`IICRC_OFS_STATUS, 8'h40);
        wb(1'b0, `IICRC_OFS_STATUS, 8'h00, rd);
        chk(rd[6], 1'b1, "flag kept on write one");
        wr(`IICRC_OFS_STATUS, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0, "flag cleared");
        for (int i = 0; i < 200 && p_busy !== 1'b0; i++) @(posedge clk_i);
        chk(p_busy, 1'b0, "stop on line");
        $display("test master transmit done");
    endtask
    // Verdict and end of run
    task end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst_i = 1'b1; standby_i = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = 4'h0; sel_i = 4'hf; dat_i = 32'h0; expanded_mode_i = 1'b0;
        n_fail = 0; checks = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_regs;
        t_standby;
        t_master;
        end_sim;
    end
    // Watchdog well beyond the expected run
    initial begin
        #80000;
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
